//--- src/ric_reset_irq_ctl.sv
// Reset generation, external interrupts, core entry/return sequencing and control register
//
// Behaviour
// - Reset from power-on, pin, or watchdog
// - Low reset pin beyond minimum width resets
// - Watchdog expiry resets only when enabled
// - Registers initialise; fetch restarts at zero
// - Hold reset for fuse-selected start-up delay
// - Interrupt pins trigger even as outputs
// - Sense field picks falling, rising, low
// - Low level requests while pin stays low
// - Entry takes four cycles before vector
// - Entry pushes two PC bytes, SP minus two
// - Vector jump takes two cycles
// - Multi-cycle instruction finishes before entry
// - Return: pop PC, SP plus two, set enable
// - One main instruction after return first
// - Flags register never saved by hardware
// - Edge flag sets only on new event
// - Level interrupt is never latched
// - Control register eight bits, resets zero
// - SRAM enable hands pins to memory
// - SRAM enable clear restores port functions
// - Reset pin acts without the clock
// - SRAM wait bit adds one wait cycle
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module ric_reset_irq_ctl
   import ric_pkg::*;
#(
   parameter int unsigned SLOW_CYC = RIC_SLOW_CYC,   // Start-up delay, slow
   parameter int unsigned FAST_CYC = RIC_FAST_CYC    // Start-up delay, fast
)(
   // Clock and reset sources
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic        ext_rst_n,
   input  wire logic        wdt_expire,
   input  wire logic        wdt_enable,
   input  wire logic        fast_startup_fuse,
   // Interrupt pins
   input  wire logic        ext_irq_pin_0,
   input  wire logic        ext_irq_pin_1,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // CPU core
   input  wire logic        core_instr_done,
   input  wire logic        core_gie,
   input  wire logic        core_reti,
   input  wire logic [15:0] core_pc,
   output ric_core_t        core_ctl,
   output logic             sys_rst_n,
   // Pin function and sleep controls
   output logic             muxed_addr_data_pins_own,
   output logic             high_addr_pins_own,
   output logic             strobe_pins_own,
   output logic             ext_sram_wait_select,
   output logic             sleep_allow,
   output logic             sleep_depth_select
);

   initial begin
      if (SLOW_CYC < 1 || FAST_CYC < 1 || SLOW_CYC >= (1 << 24) || FAST_CYC >= (1 << 24)) begin
         $error("ric_reset_irq_ctl: delay counts out of range");
      end
   end

   // ************************************************************
   // Reset generation
   // ************************************************************
   logic        arst_n;      // Combined asynchronous reset
   logic        pend_q;      // Delay not yet loaded
   logic [23:0] cnt_q;       // Start-up delay down-counter
   logic [23:0] delay;       // Delay chosen by fuse
   logic        wdt_trip;    // Enabled watchdog expiry
   logic        in_rst;      // Internal reset active
   logic        sys_rst_n_q; // Registered reset out

   // Power-on and pin act asynchronously, clock or no clock
   assign arst_n   = rst_n & por_n & ext_rst_n;
   assign wdt_trip = wdt_expire & wdt_enable;
   assign delay    = fast_startup_fuse ? FAST_CYC[23:0] : SLOW_CYC[23:0];
   assign in_rst   = pend_q | (cnt_q != 24'h000000);

   // Any source reloads the full delay; count down to release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_q <= 1'b1;
         cnt_q  <= 24'h000000;
      end else if (pend_q | wdt_trip) begin
         pend_q <= 1'b0;
         cnt_q  <= delay;
      end else if (cnt_q != 24'h000000) begin
         cnt_q  <= cnt_q - 24'h000001;
      end
   end

   // Reset output follows hold state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_rst_n_q <= 1'b0;
      end else begin
         sys_rst_n_q <= ~in_rst;
      end
   end

   assign sys_rst_n = sys_rst_n_q;

   // ************************************************************
   // Register bus
   // ************************************************************
   logic [7:0]  mcu_q;       // mcu_general_control
   logic [1:0]  irq_en_q;    // Interrupt enables
   logic        wait_q;      // Waitrequest
   logic [31:0] rdata_q;     // Read data
   logic        req;         // Request present
   logic        acc;         // Request accepted this edge
   logic [5:0]  idx;         // Register index
   logic        wr_mcu;      // Write to control register
   logic        wr_en;       // Write to enable register
   logic        wr_flag;     // Write-one-to-clear flags
   logic [31:0] rmux;        // Read mux
   logic [1:0]  flag;        // Edge flags
   logic [1:0]  lvl;         // Level requests
   logic [1:0]  irq_req;     // Requests to sequencer
   logic [1:0]  hw_ack;      // Flag clear on entry

   assign req     = avs_read | avs_write;
   assign acc     = req & ~wait_q;
   assign idx     = avs_address[7:2];
   assign wr_mcu  = acc & avs_write & avs_byteenable[0] & (idx == RIC_IDX_MCU_CTRL) & ~in_rst;
   assign wr_en   = acc & avs_write & avs_byteenable[0] & (idx == RIC_IDX_IRQ_EN) & ~in_rst;
   assign wr_flag = acc & avs_write & avs_byteenable[0] & (idx == RIC_IDX_IRQ_FLAG);
   assign rmux    = (idx == RIC_IDX_MCU_CTRL) ? {24'h000000, mcu_q} :
                    (idx == RIC_IDX_IRQ_EN)   ? {30'h00000000, irq_en_q} :
                    (idx == RIC_IDX_IRQ_FLAG) ? {28'h0000000, lvl, flag} : 32'h00000000;

   // One wait cycle, then accept; unmapped reads give zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q  <= ~(req & wait_q);
         rdata_q <= (req & wait_q) ? rmux : rdata_q;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;

   // Control registers return to initial values while in reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mcu_q    <= RIC_MCU_RESET;
         irq_en_q <= 2'h0;
      end else if (in_rst) begin
         mcu_q    <= RIC_MCU_RESET;
         irq_en_q <= 2'h0;
      end else begin
         mcu_q    <= wr_mcu ? avs_writedata[7:0] : mcu_q;
         irq_en_q <= wr_en ? avs_writedata[1:0] : irq_en_q;
      end
   end

   // Memory pins taken over when set, ports restored when clear
   assign muxed_addr_data_pins_own = mcu_q[RIC_B_SRAM_EN];
   assign high_addr_pins_own       = mcu_q[RIC_B_SRAM_EN];
   assign strobe_pins_own          = mcu_q[RIC_B_SRAM_EN];
   assign ext_sram_wait_select     = mcu_q[RIC_B_SRAM_WAIT];
   assign sleep_allow              = mcu_q[RIC_B_SLEEP_ALLOW];
   assign sleep_depth_select       = mcu_q[RIC_B_SLEEP_DEPTH];

   // ************************************************************
   // External interrupt inputs
   // ************************************************************
   ric_irq_sense u_sense0 (
      .clk       (clk),
      .arst_n    (arst_n),
      .srst      (in_rst),
      .pin       (ext_irq_pin_0),
      .sense     (mcu_q[RIC_F_IRQ0_LO +: 2]),
      .enable    (irq_en_q[0]),
      .clr       ((wr_flag & avs_writedata[0]) | hw_ack[0]),
      .flag_q    (flag[0]),
      .level_req (lvl[0]),
      .req       (irq_req[0])
   );

   ric_irq_sense u_sense1 (
      .clk       (clk),
      .arst_n    (arst_n),
      .srst      (in_rst),
      .pin       (ext_irq_pin_1),
      .sense     (mcu_q[RIC_F_IRQ1_LO +: 2]),
      .enable    (irq_en_q[1]),
      .clr       ((wr_flag & avs_writedata[1]) | hw_ack[1]),
      .flag_q    (flag[1]),
      .level_req (lvl[1]),
      .req       (irq_req[1])
   );

   // ************************************************************
   // Entry and return sequencer
   // ************************************************************
   ric_state_t  st_q;        // Sequencer state
   ric_state_t  st_d;
   logic [1:0]  cnt2_q;      // Cycle within state
   logic [1:0]  cnt2_d;
   logic        sel_q;       // Interrupt being served
   logic        take;        // Start entry
   logic        restart;     // Reset just released
   ric_core_t   ctl_q;       // Core strobes
   ric_core_t   ctl_d;

   // Entry only at an instruction boundary with global enable
   assign take    = core_instr_done & core_gie & (|irq_req) & ~in_rst;
   assign restart = ~sys_rst_n_q & ~in_rst;
   assign hw_ack  = (st_q == RIC_ST_ENTRY && cnt2_q == 2'h0) ? {sel_q, ~sel_q} : 2'h0;

   // Next state and counter
   always_comb begin
      st_d   = st_q;
      cnt2_d = cnt2_q + 2'h1;
      unique case (st_q)
         RIC_ST_RUN: begin
            cnt2_d = 2'h0;
            if (take) begin
               st_d = RIC_ST_ENTRY;
            end else if (core_reti) begin
               st_d = RIC_ST_RETURN;
            end
         end
         RIC_ST_ENTRY: begin
            if (cnt2_q == 2'(RIC_ENTRY_CYC - 1)) begin
               st_d   = RIC_ST_VJUMP;
               cnt2_d = 2'h0;
            end
         end
         RIC_ST_VJUMP: begin
            if (cnt2_q == 2'(RIC_VJUMP_CYC - 1)) begin
               st_d   = RIC_ST_RUN;
            end
         end
         RIC_ST_RETURN: begin
            if (cnt2_q == 2'(RIC_RETURN_CYC - 1)) begin
               st_d   = RIC_ST_AFTER;
            end
         end
         RIC_ST_AFTER: begin
            cnt2_d = 2'h0;
            if (core_instr_done) begin
               st_d = RIC_ST_RUN;
            end
         end
      endcase
   end

   // Core strobes; status flags are never saved or restored here
   always_comb begin
      ctl_d           = '0;
      ctl_d.hold      = (st_d != RIC_ST_RUN) & (st_d != RIC_ST_AFTER);
      ctl_d.vaddr     = ctl_q.vaddr;
      ctl_d.sdata     = ctl_q.sdata;
      if (restart) begin
         ctl_d.vec_load = 1'b1;
         ctl_d.vaddr    = RIC_VEC_RESET;
      end
      if (st_q == RIC_ST_ENTRY) begin
         ctl_d.push      = (cnt2_q == 2'h0) | (cnt2_q == 2'h1);
         ctl_d.sdata     = (cnt2_q == 2'h0) ? core_pc[7:0] : core_pc[15:8];
         ctl_d.gie_clear = (cnt2_q == 2'h0);
         ctl_d.sp_dec2   = (cnt2_q == 2'h1);
         ctl_d.vec_load  = (cnt2_q == 2'(RIC_ENTRY_CYC - 1));
         ctl_d.vaddr     = sel_q ? RIC_VEC_IRQ1 : RIC_VEC_IRQ0;
      end
      if (st_q == RIC_ST_RETURN) begin
         ctl_d.pop     = (cnt2_q == 2'h0) | (cnt2_q == 2'h1);
         ctl_d.sp_inc2 = (cnt2_q == 2'h1);
         ctl_d.gie_set = (cnt2_q == 2'(RIC_RETURN_CYC - 1));
      end
   end

   // Sequencer registers; irq 0 wins over irq 1
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q   <= RIC_ST_RUN;
         cnt2_q <= 2'h0;
         sel_q  <= 1'b0;
         ctl_q  <= '0;
      end else if (in_rst) begin
         st_q   <= RIC_ST_RUN;
         cnt2_q <= 2'h0;
         sel_q  <= 1'b0;
         ctl_q  <= '0;
      end else begin
         st_q   <= st_d;
         cnt2_q <= cnt2_d;
         sel_q  <= (st_q == RIC_ST_RUN && take) ? ~irq_req[0] : sel_q;
         ctl_q  <= ctl_d;
      end
   end

   assign core_ctl = ctl_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_rst_hold;
      @(posedge clk) disable iff (!arst_n)
      (cnt_q != 24'h000000) |=> !sys_rst_n_q;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset released during delay");

   property p_wdt;
      @(posedge clk) disable iff (!arst_n)
      (wdt_expire && wdt_enable) |=> (cnt_q == delay) ##1 !sys_rst_n_q;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog did not restart delay");

   property p_entry;
      @(posedge clk) disable iff (!arst_n || in_rst)
      (st_q == RIC_ST_RUN && take) |=> (st_q == RIC_ST_ENTRY)[*4] ##1 (st_q == RIC_ST_VJUMP)[*2]
         ##1 (st_q == RIC_ST_RUN);
   endproperty
   a_entry: assert property (p_entry) else $error("entry or vector jump length wrong");

   property p_push;
      @(posedge clk) disable iff (!arst_n || in_rst)
      (st_q == RIC_ST_ENTRY && cnt2_q == 2'h0) |=> ctl_q.push && ctl_q.sdata == $past(core_pc[7:0])
         ##1 ctl_q.push && ctl_q.sp_dec2 ##2 ctl_q.vec_load;
   endproperty
   a_push: assert property (p_push) else $error("entry push sequence wrong");

   property p_ret;
      @(posedge clk) disable iff (!arst_n || in_rst)
      (st_q == RIC_ST_RUN && !take && core_reti) |=> (st_q == RIC_ST_RETURN)[*4] ##1 ctl_q.gie_set;
   endproperty
   a_ret: assert property (p_ret) else $error("return sequence wrong");

   property p_after;
      @(posedge clk) disable iff (!arst_n || in_rst)
      (st_q == RIC_ST_AFTER && !core_instr_done) |=> (st_q == RIC_ST_AFTER);
   endproperty
   a_after: assert property (p_after) else $error("interrupt served before one instruction");

   property p_multi;
      @(posedge clk) disable iff (!arst_n || in_rst)
      (st_q == RIC_ST_RUN && !core_instr_done) |=> (st_q != RIC_ST_ENTRY);
   endproperty
   a_multi: assert property (p_multi) else $error("entry inside an instruction");

   property p_wr;
      @(posedge clk) disable iff (!arst_n)
      wr_mcu |=> (mcu_q == $past(avs_writedata[7:0])) && (muxed_addr_data_pins_own == mcu_q[7]);
   endproperty
   a_wr: assert property (p_wr) else $error("control register write lost");

   c_entry: cover property (@(posedge clk) disable iff (!arst_n) ctl_q.vec_load && ctl_q.vaddr == RIC_VEC_IRQ1);
   c_ret:   cover property (@(posedge clk) disable iff (!arst_n) ctl_q.gie_set);
   c_wdt:   cover property (@(posedge clk) disable iff (!arst_n) wdt_trip && sys_rst_n_q);

endmodule : ric_reset_irq_ctl

//--- src/ric_pkg.sv
// Package: constants and carrier types for the reset and interrupt control block
package ric_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam real         RIC_CLK_MHZ         = 125.0;   // System clock rate
   localparam real         RIC_DELAY_SLOW_MS   = 16.0;    // Start-up delay, fuse unprogrammed
   localparam real         RIC_DELAY_FAST_MS   = 0.28;    // Start-up delay, fuse programmed
   localparam int unsigned RIC_SLOW_CYC        = int'(RIC_DELAY_SLOW_MS * RIC_CLK_MHZ * 1000.0);
   localparam int unsigned RIC_FAST_CYC        = int'(RIC_DELAY_FAST_MS * RIC_CLK_MHZ * 1000.0);
   localparam int unsigned RIC_ENTRY_CYC       = 4;       // Interrupt entry length
   localparam int unsigned RIC_RETURN_CYC      = 4;       // Interrupt return length
   localparam int unsigned RIC_VJUMP_CYC       = 2;       // Vector relative jump length

   // ************************************************************
   // Register map (index; byte address is four times it)
   // ************************************************************
   localparam logic [5:0]  RIC_IDX_MCU_CTRL    = 6'h35;   // mcu_general_control
   localparam logic [5:0]  RIC_IDX_IRQ_EN      = 6'h36;   // Interrupt enables
   localparam logic [5:0]  RIC_IDX_IRQ_FLAG    = 6'h37;   // Flags and level requests
   localparam logic [7:0]  RIC_MCU_RESET       = 8'h00;   // mcu_general_control after reset

   // ************************************************************
   // Field positions of mcu_general_control
   // ************************************************************
   localparam int          RIC_B_SRAM_EN       = 7;       // ext_sram_enable
   localparam int          RIC_B_SRAM_WAIT     = 6;       // ext_sram_wait_select
   localparam int          RIC_B_SLEEP_ALLOW   = 5;       // sleep_allow
   localparam int          RIC_B_SLEEP_DEPTH   = 4;       // sleep_depth_select
   localparam int          RIC_F_IRQ1_LO       = 2;       // Low bit of irq1 sense field
   localparam int          RIC_F_IRQ0_LO       = 0;       // Low bit of irq0 sense field

   // ************************************************************
   // Sense codes and vectors
   // ************************************************************
   localparam logic [1:0]  RIC_SENSE_LOW       = 2'h0;    // Low level
   localparam logic [1:0]  RIC_SENSE_NONE      = 2'h1;    // No trigger
   localparam logic [1:0]  RIC_SENSE_FALL      = 2'h2;    // Falling edge
   localparam logic [1:0]  RIC_SENSE_RISE      = 2'h3;    // Rising edge
   localparam logic [15:0] RIC_VEC_RESET       = 16'h0000; // Fetch address after reset
   localparam logic [15:0] RIC_VEC_IRQ0        = 16'h0001; // Vector of irq 0
   localparam logic [15:0] RIC_VEC_IRQ1        = 16'h0002; // Vector of irq 1

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [4:0] {
      RIC_ST_RUN    = 5'h01,
      RIC_ST_ENTRY  = 5'h02,
      RIC_ST_VJUMP  = 5'h04,
      RIC_ST_RETURN = 5'h08,
      RIC_ST_AFTER  = 5'h10
   } ric_state_t;

   // Strobes toward the CPU core
   typedef struct packed {
      logic        hold;        // Core stalled by sequencer
      logic        push;        // Write sdata to stack
      logic        pop;         // Read byte from stack
      logic        sp_dec2;     // Stack pointer minus two
      logic        sp_inc2;     // Stack pointer plus two
      logic        gie_clear;   // Clear global enable
      logic        gie_set;     // Set global enable
      logic        vec_load;    // Load vaddr into program counter
      logic [7:0]  sdata;       // Byte to push
      logic [15:0] vaddr;       // Fetch address
   } ric_core_t;

endpackage : ric_pkg

//--- src/ric_irq_sense.sv
// External interrupt pin synchroniser, sense selection and flag
`timescale 1ns/1ps
module ric_irq_sense
   import ric_pkg::*;
(
   // Clock and resets
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       srst,
   // Pin and control
   input  wire logic       pin,
   input  wire logic [1:0] sense,
   input  wire logic       enable,
   input  wire logic       clr,
   // Status
   output logic            flag_q,
   output logic            level_req,
   output logic            req
);

   logic sync1_q;   // First synchroniser stage
   logic sync2_q;   // Second synchroniser stage
   logic prev_q;    // Delayed synced level
   logic fall;      // Falling edge seen
   logic rise;      // Rising edge seen
   logic edge_hit;  // Selected edge seen

   // ************************************************************
   // Synchroniser and edge detection
   // ************************************************************
   // Pin level is sampled whatever its direction, so driving it triggers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign fall     = prev_q & ~sync2_q;
   assign rise     = ~prev_q & sync2_q;
   assign edge_hit = ((sense == RIC_SENSE_FALL) & fall) | ((sense == RIC_SENSE_RISE) & rise);

   // ************************************************************
   // Edge flag: set on the event only, set wins over clear
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (srst) begin
         flag_q <= 1'b0;
      end else if (edge_hit) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end

   // Level request is not latched, it lasts while the pin is low
   assign level_req = (sense == RIC_SENSE_LOW) & ~sync2_q;
   assign req       = enable & (level_req | flag_q);

endmodule : ric_irq_sense

//--- verification/ric_core_model.sv
// CPU core stand-in facing the reset and interrupt control block
`timescale 1ns/1ps
module ric_core_model
   import ric_pkg::*;
(
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Strobes from the block
   input  ric_core_t  ctl,
   // Core status
   output logic       instr_done,
   output logic       gie,
   output logic       reti,
   output logic [15:0] pc
);
   logic [2:0] hnd_q;   // Handler length countdown
   logic       mc_q;    // Second cycle of a two-cycle instruction
   // No instruction completes while stalled, nor half-way through a two-cycle one
   assign instr_done = !ctl.hold & mc_q;
   assign pc         = 16'h1234;    // Fixed return address
   // Global enable flag and short handler ending in a return
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gie   <= 1'b1;
         hnd_q <= 3'h0;
         reti  <= 1'b0;
         mc_q  <= 1'b0;
      end else begin
         mc_q <= ~mc_q;
         if (ctl.gie_clear) gie <= 1'b0;
         else if (ctl.gie_set) gie <= 1'b1;
         reti <= (hnd_q == 3'h1);
         if (ctl.vec_load && ctl.vaddr != RIC_VEC_RESET) hnd_q <= 3'h6;
         else if (hnd_q != 3'h0) hnd_q <= hnd_q - 3'h1;
      end
   end
endmodule : ric_core_model

//--- verification/tb.sv
// Self-checking bench of the reset and interrupt control block
`timescale 1ns/1ps
module tb;
   import ric_pkg::*;
   localparam int SL = 20;   // Short slow delay
   localparam int FA = 5;    // Short fast delay
   logic clk = 0, rst_n = 0, ext_rst_n = 1, wdt_expire = 0, wdt_enable = 0, fuse = 0, por_n = 1;
   logic p0 = 1, p1 = 1, rd = 0, wr = 0, wrq, srn, done, gie, reti;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdata, r;
   logic [15:0] pc;
   ric_core_t cc;
   logic [5:0] pins;   // Pin owners, wait, sleep bits
   int fails = 0, check_count = 0, n;
   always #4 clk = ~clk;
   ric_reset_irq_ctl #(.SLOW_CYC(SL), .FAST_CYC(FA)) dut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
      .ext_rst_n(ext_rst_n), .wdt_expire(wdt_expire), .wdt_enable(wdt_enable), .fast_startup_fuse(fuse),
      .ext_irq_pin_0(p0), .ext_irq_pin_1(p1), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wrq),
      .core_instr_done(done), .core_gie(gie), .core_reti(reti), .core_pc(pc), .core_ctl(cc),
      .sys_rst_n(srn), .muxed_addr_data_pins_own(pins[5]), .high_addr_pins_own(pins[4]),
      .strobe_pins_own(pins[3]), .ext_sram_wait_select(pins[2]), .sleep_allow(pins[1]),
      .sleep_depth_select(pins[0]));
   ric_core_model u_core (.clk(clk), .rst_n(srn), .ctl(cc), .instr_done(done), .gie(gie), .reti(reti), .pc(pc));
   // ************
   // Helpers
   // ************
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask : chk
   task results;
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   // Avalon-MM access held until waitrequest is sampled low
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int k;
      k = 0;
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= {24'h0, d};
      @(posedge clk);
      while (wrq !== 1'b0 && k < 50) begin
         @(posedge clk);
         k++;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50) begin
         fails++;
         results;
      end
      @(posedge clk);
   endtask : bus
   // Count edges until internal reset lifts
   task rel(input int lo);
      n = 0;
      while (srn !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) begin
         fails++;
         results;
      end
      chk(n >= lo - 3 && n <= lo + 4, 1);
      chk({cc.vec_load, cc.vaddr}, {1'b1, RIC_VEC_RESET});
   endtask : rel
   // ************
   // Scenarios
   // ************
   task t_regs;
      bus(1, 8'hD4, 8'hC5, r);
      bus(0, 8'hD4, 8'h00, r);
      chk(r, 32'h000000C5);
      chk(pins, 6'h3C);
      bus(1, 8'hD4, 8'h30, r);
      chk(pins, 6'h03);
      bus(0, 8'hF0, 8'h00, r);
      chk(r, 32'h0);
   endtask : t_regs
   task t_irq;
      bus(1, 8'hD4, 8'h02, r);
      bus(1, 8'hD8, 8'h03, r);
      p0 <= 1'b0;
      n = 0;
      while (cc.push !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) begin
         fails++;
         results;
      end
      chk({cc.gie_clear, cc.sdata}, {1'b1, 8'h34});
      @(posedge clk) chk({cc.push, cc.sp_dec2, cc.sdata}, {2'b11, 8'h12});
      repeat (2) @(posedge clk);
      chk({cc.vec_load, cc.vaddr}, {1'b1, RIC_VEC_IRQ0});
      @(posedge clk) chk(cc.hold, 1);
      @(posedge clk) chk(cc.hold, 0);
      while (cc.pop !== 1'b1 && n < 80) begin
         @(posedge clk);
         n++;
      end
      if (n >= 80) begin
         fails++;
         results;
      end
      @(posedge clk) chk({cc.pop, cc.sp_inc2}, 2'b11);
      repeat (2) @(posedge clk);
      chk(cc.gie_set, 1);
      bus(0, 8'hDC, 8'h00, r);
      chk(r, 32'h0);
      p1 <= 1'b0;
      repeat (4) @(posedge clk);
      bus(0, 8'hDC, 8'h00, r);
      chk(r[3], 1);
      p1 <= 1'b1;
      repeat (4) @(posedge clk);
      bus(0, 8'hDC, 8'h00, r);
      chk(r[3], 0);
   endtask : t_irq
   task t_wdt;
      wdt_expire <= 1'b1;
      @(posedge clk) wdt_expire <= 1'b0;
      repeat (3) @(posedge clk);
      chk(srn, 1);
      fuse <= 1'b1;
      wdt_enable <= 1'b1;
      wdt_expire <= 1'b1;
      @(posedge clk) wdt_expire <= 1'b0;
      repeat (2) @(posedge clk);
      chk(srn, 0);
      wdt_expire <= 1'b1;
      @(posedge clk) wdt_expire <= 1'b0;
      repeat (4) @(posedge clk);
      chk(srn, 0);
      rel(FA);
   endtask : t_wdt
   task t_ext;
      bus(1, 8'hD4, 8'hA5, r);
      fuse <= 1'b0;
      ext_rst_n <= 1'b0;
      #2 chk(srn, 0);
      repeat (7) @(posedge clk);
      ext_rst_n <= 1'b1;
      rel(SL);
      bus(0, 8'hD4, 8'h00, r);
      chk(r, 32'h0);
      por_n <= 1'b0;
      @(posedge clk) chk(srn, 0);
      por_n <= 1'b1;
      rel(SL);
   endtask : t_ext
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rel(SL);
      t_regs;
      t_irq;
      t_wdt;
      t_ext;
      results;
   end
endmodule : tb
